// *** logic/ubrb_pkg.sv ***
package ubrb_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned REG_COUNT = 32;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] A_HOLDING = 5'h00;
   localparam logic [4:0] A_INTERRUPT_ENABLE = 5'h01;
   localparam logic [4:0] A_INTERRUPT_STATUS = 5'h02;
   localparam logic [4:0] A_LINE_STATUS_INT_ENABLE = 5'h03;
   localparam logic [4:0] A_LINE_STATUS = 5'h04;
   localparam logic [4:0] A_SPECIAL_CHAR_INT_ENABLE = 5'h05;
   localparam logic [4:0] A_SPECIAL_CHAR_STATUS = 5'h06;
   localparam logic [4:0] A_MISC_STATUS_INT_ENABLE = 5'h07;
   localparam logic [4:0] A_MISC_STATUS = 5'h08;
   localparam logic [4:0] A_MODE_CONTROL_1 = 5'h09;
   localparam logic [4:0] A_MODE_CONTROL_2 = 5'h0A;
   localparam logic [4:0] A_LINE_CONTROL = 5'h0B;
   localparam logic [4:0] A_RECEIVE_TIMEOUT = 5'h0C;
   localparam logic [4:0] A_HALF_DUPLEX_DELAY = 5'h0D;
   localparam logic [4:0] A_INFRARED_CODING_CONTROL = 5'h0E;
   localparam logic [4:0] A_FLOW_HALT_RESUME_LEVELS = 5'h0F;
   localparam logic [4:0] A_FIFO_TRIGGER_LEVELS = 5'h10;
   localparam logic [4:0] A_TX_FILL_COUNT = 5'h11;
   localparam logic [4:0] A_RX_FILL_COUNT = 5'h12;
   localparam logic [4:0] A_FLOW_CONTROL_SETUP = 5'h13;
   localparam logic [4:0] A_RESUME_CHAR_1 = 5'h14;
   localparam logic [4:0] A_RESUME_CHAR_2 = 5'h15;
   localparam logic [4:0] A_PAUSE_CHAR_1 = 5'h16;
   localparam logic [4:0] A_PAUSE_CHAR_2 = 5'h17;
   localparam logic [4:0] A_PIN_DIRECTION_DRIVE = 5'h18;
   localparam logic [4:0] A_PIN_LEVELS = 5'h19;
   localparam logic [4:0] A_MULTIPLIER_PREDIVIDER_CONFIG = 5'h1A;
   localparam logic [4:0] A_BAUD_GENERATOR_CONFIG = 5'h1B;
   localparam logic [4:0] A_BAUD_DIVISOR_LOW = 5'h1C;
   localparam logic [4:0] A_BAUD_DIVISOR_HIGH = 5'h1D;
   localparam logic [4:0] A_CLOCK_SOURCE_SELECT = 5'h1E;
   localparam logic [4:0] A_REVISION_CODE = 5'h1F;

   // ----------------------------------------------------------------
   // reset values, field masks and positions
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_INTERRUPT_STATUS = 8'h60;
   localparam logic [7:0] RST_LINE_CONTROL = 8'h05;
   localparam logic [7:0] RST_FIFO_TRIGGER_LEVELS = 8'hFF;
   localparam logic [7:0] RST_MULTIPLIER_PREDIVIDER = 8'h01;
   localparam logic [7:0] RST_BAUD_DIVISOR_LOW = 8'h01;
   localparam logic [7:0] RST_CLOCK_SOURCE_SELECT = 8'h08;
   localparam logic [7:0] MASK_ALL = 8'hFF;
   localparam logic [7:0] MASK_LOW6 = 8'h3F;
   localparam logic [7:0] MASK_LINE_STATUS = 8'hBF;
   localparam logic [7:0] MASK_MISC_ENABLE = 8'h6F;
   localparam logic [7:0] MASK_MISC_LATCHED = 8'h4F;
   localparam logic [7:0] MASK_CLOCK_SOURCE = 8'h9F;
   localparam int unsigned CLOCK_READY_BIT = 5;
   localparam int unsigned FIFO_FLUSH_BIT = 1;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [7:0] wdata;
   } ubrb_host_req_t;

   typedef struct packed {
      logic [7:0] interrupt_enable;
      logic [7:0] line_status_int_enable;
      logic [7:0] special_char_int_enable;
      logic [7:0] misc_status_int_enable;
      logic [7:0] mode_control_1;
      logic [7:0] mode_control_2;
      logic [7:0] line_control;
      logic [7:0] receive_timeout;
      logic [7:0] half_duplex_delay;
      logic [7:0] infrared_coding_control;
      logic [7:0] flow_halt_resume_levels;
      logic [7:0] fifo_trigger_levels;
      logic [7:0] flow_control_setup;
      logic [7:0] resume_char_1;
      logic [7:0] resume_char_2;
      logic [7:0] pause_char_1;
      logic [7:0] pause_char_2;
      logic [7:0] pin_direction_drive;
      logic [7:0] pin_levels;
      logic [7:0] multiplier_predivider_config;
      logic [7:0] baud_generator_config;
      logic [7:0] baud_divisor_low;
      logic [7:0] baud_divisor_high;
      logic [7:0] clock_source_select;
   } ubrb_cfg_t;

   // ----------------------------------------------------------------
   // decoding of the plain read/write registers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rw_mask(input logic [4:0] a);
      logic [7:0] m;
      m = MASK_ALL;
      unique case (a)
         A_HOLDING, A_INTERRUPT_STATUS, A_LINE_STATUS,
         A_SPECIAL_CHAR_STATUS, A_MISC_STATUS, A_TX_FILL_COUNT,
         A_RX_FILL_COUNT, A_REVISION_CODE: m = 8'h00;
         A_LINE_STATUS_INT_ENABLE, A_SPECIAL_CHAR_INT_ENABLE,
         A_INFRARED_CODING_CONTROL, A_BAUD_GENERATOR_CONFIG: m = MASK_LOW6;
         A_MISC_STATUS_INT_ENABLE: m = MASK_MISC_ENABLE;
         A_CLOCK_SOURCE_SELECT: m = MASK_CLOCK_SOURCE;
         default: m = MASK_ALL;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] rw_reset(input logic [4:0] a);
      logic [7:0] v;
      v = RST_ZERO;
      unique case (a)
         A_LINE_CONTROL: v = RST_LINE_CONTROL;
         A_FIFO_TRIGGER_LEVELS: v = RST_FIFO_TRIGGER_LEVELS;
         A_MULTIPLIER_PREDIVIDER_CONFIG: v = RST_MULTIPLIER_PREDIVIDER;
         A_BAUD_DIVISOR_LOW: v = RST_BAUD_DIVISOR_LOW;
         A_CLOCK_SOURCE_SELECT: v = RST_CLOCK_SOURCE_SELECT;
         default: v = RST_ZERO;
      endcase
      return v;
   endfunction

endpackage

// *** logic/ubrb_cor_status.sv ***
// sticky status byte that clears its latched bits when read
module ubrb_cor_status #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] LATCH_MASK = 8'hFF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // events and clear
   input wire logic [7:0] set_bits,
   input wire logic read_clear,
   // state
   output logic [7:0] value
);

   // ----------------------------------------------------------------
   // latch
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         value <= RESET_VALUE;
      else if (read_clear)
         value <= (value & ~LATCH_MASK) | (set_bits & LATCH_MASK);
      else
         value <= value | (set_bits & LATCH_MASK);
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_cor_clear;
      @(posedge core_clk) disable iff (rst)
      read_clear && (set_bits == 8'h00) |=> value == 8'h00;
   endproperty
   a_cor_clear: assert property (p_cor_clear)
      else $error("read did not clear status");

   property p_set_wins;
      @(posedge core_clk) disable iff (rst)
      read_clear |=> (value & LATCH_MASK) == ($past(set_bits) & LATCH_MASK);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost during clearing read");

endmodule

// *** logic/ubrb_regs.sv ***
// Notes on behaviour
// - unlisted registers reset to zero
// - plain registers read back last masked write
// - interrupt status resets 0x60, line control 0x05
// - trigger levels reset 0xFF, multiplier 0x01
// - divisor low resets 0x01, clock source 0x08
// - interrupt and special status clear on read
// - misc status clears on read, line status not
// - fill counts are read-only live values
// - revision is fixed nonzero, read-only
// - all registers eight bits over host port
// - receive read pops oldest receive word
// - transmit write pushes byte into transmit fifo
// - mode two flush bit clears both fifos
module ubrb_regs #(
   // arbitrary nonzero identification value
   parameter logic [7:0] REVISION_CODE = 8'h5C
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host register port
   input wire ubrb_pkg::ubrb_host_req_t host_req,
   output logic [7:0] host_rdata,
   // receive fifo
   input wire logic [7:0] rx_head_data,
   input wire logic [7:0] rx_count,
   output logic rx_pop,
   // transmit fifo
   input wire logic [7:0] tx_count,
   output logic tx_push,
   output logic [7:0] tx_push_data,
   // fifo flush
   output logic fifo_flush,
   // status sources
   input wire logic [7:0] interrupt_events,
   input wire logic [7:0] line_status,
   input wire logic [7:0] special_char_events,
   input wire logic [7:0] misc_events,
   input wire logic clock_ready,
   // configuration
   output ubrb_pkg::ubrb_cfg_t cfg
);

   logic [7:0] rw_q [ubrb_pkg::REG_COUNT];
   logic [7:0] read_value;
   logic [7:0] interrupt_status;
   logic [7:0] special_char_status;
   logic [7:0] misc_status;
   logic [7:0] misc_view;
   logic rd_interrupt_status;
   logic rd_special_char_status;
   logic rd_misc_status;
   logic wr_holding;

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   function automatic logic hit(input ubrb_pkg::ubrb_host_req_t r,
                                input logic is_read,
                                input logic [4:0] a);
      logic strobe;
      strobe = is_read ? r.rd : r.wr;
      return strobe && (r.addr == a);
   endfunction

   assign rd_interrupt_status =
      hit(host_req, 1'b1, ubrb_pkg::A_INTERRUPT_STATUS);
   assign rd_special_char_status =
      hit(host_req, 1'b1, ubrb_pkg::A_SPECIAL_CHAR_STATUS);
   assign rd_misc_status = hit(host_req, 1'b1, ubrb_pkg::A_MISC_STATUS);
   assign wr_holding = hit(host_req, 1'b0, ubrb_pkg::A_HOLDING);

   // ----------------------------------------------------------------
   // plain read/write registers
   // ----------------------------------------------------------------
   // non read/write slots have a zero mask, so writes there are dropped
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < ubrb_pkg::REG_COUNT; i++)
            rw_q[i] <= ubrb_pkg::rw_reset(5'(i));
      end
      else if (host_req.wr &&
               ubrb_pkg::rw_mask(host_req.addr) != 8'h00)
      begin
         rw_q[host_req.addr] <=
            host_req.wdata & ubrb_pkg::rw_mask(host_req.addr);
      end
   end

   // ----------------------------------------------------------------
   // configuration outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      cfg.interrupt_enable = rw_q[ubrb_pkg::A_INTERRUPT_ENABLE];
      cfg.line_status_int_enable = rw_q[ubrb_pkg::A_LINE_STATUS_INT_ENABLE];
      cfg.special_char_int_enable =
         rw_q[ubrb_pkg::A_SPECIAL_CHAR_INT_ENABLE];
      cfg.misc_status_int_enable = rw_q[ubrb_pkg::A_MISC_STATUS_INT_ENABLE];
      cfg.mode_control_1 = rw_q[ubrb_pkg::A_MODE_CONTROL_1];
      cfg.mode_control_2 = rw_q[ubrb_pkg::A_MODE_CONTROL_2];
      cfg.line_control = rw_q[ubrb_pkg::A_LINE_CONTROL];
      cfg.receive_timeout = rw_q[ubrb_pkg::A_RECEIVE_TIMEOUT];
      cfg.half_duplex_delay = rw_q[ubrb_pkg::A_HALF_DUPLEX_DELAY];
      cfg.infrared_coding_control =
         rw_q[ubrb_pkg::A_INFRARED_CODING_CONTROL];
      cfg.flow_halt_resume_levels =
         rw_q[ubrb_pkg::A_FLOW_HALT_RESUME_LEVELS];
      cfg.fifo_trigger_levels = rw_q[ubrb_pkg::A_FIFO_TRIGGER_LEVELS];
      cfg.flow_control_setup = rw_q[ubrb_pkg::A_FLOW_CONTROL_SETUP];
      cfg.resume_char_1 = rw_q[ubrb_pkg::A_RESUME_CHAR_1];
      cfg.resume_char_2 = rw_q[ubrb_pkg::A_RESUME_CHAR_2];
      cfg.pause_char_1 = rw_q[ubrb_pkg::A_PAUSE_CHAR_1];
      cfg.pause_char_2 = rw_q[ubrb_pkg::A_PAUSE_CHAR_2];
      cfg.pin_direction_drive = rw_q[ubrb_pkg::A_PIN_DIRECTION_DRIVE];
      cfg.pin_levels = rw_q[ubrb_pkg::A_PIN_LEVELS];
      cfg.multiplier_predivider_config =
         rw_q[ubrb_pkg::A_MULTIPLIER_PREDIVIDER_CONFIG];
      cfg.baud_generator_config = rw_q[ubrb_pkg::A_BAUD_GENERATOR_CONFIG];
      cfg.baud_divisor_low = rw_q[ubrb_pkg::A_BAUD_DIVISOR_LOW];
      cfg.baud_divisor_high = rw_q[ubrb_pkg::A_BAUD_DIVISOR_HIGH];
      cfg.clock_source_select = rw_q[ubrb_pkg::A_CLOCK_SOURCE_SELECT];
   end

   // ----------------------------------------------------------------
   // clear-on-read status
   // ----------------------------------------------------------------
   ubrb_cor_status #(
      .RESET_VALUE(ubrb_pkg::RST_INTERRUPT_STATUS),
      .LATCH_MASK(ubrb_pkg::MASK_ALL)
   ) u_interrupt_status (
      .core_clk(core_clk),
      .rst(rst),
      .set_bits(interrupt_events),
      .read_clear(rd_interrupt_status),
      .value(interrupt_status)
   );

   ubrb_cor_status #(
      .RESET_VALUE(ubrb_pkg::RST_ZERO),
      .LATCH_MASK(ubrb_pkg::MASK_LOW6)
   ) u_special_char_status (
      .core_clk(core_clk),
      .rst(rst),
      .set_bits(special_char_events),
      .read_clear(rd_special_char_status),
      .value(special_char_status)
   );

   // clock-ready is a live level; bits 0-3 and 6 latch, bits 4 and 7 read zero
   ubrb_cor_status #(
      .RESET_VALUE(ubrb_pkg::RST_ZERO),
      .LATCH_MASK(ubrb_pkg::MASK_MISC_LATCHED)
   ) u_misc_status (
      .core_clk(core_clk),
      .rst(rst),
      .set_bits(misc_events),
      .read_clear(rd_misc_status),
      .value(misc_status)
   );

   always_comb
   begin
      misc_view = misc_status;
      misc_view[ubrb_pkg::CLOCK_READY_BIT] = clock_ready;
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (host_req.addr)
         ubrb_pkg::A_HOLDING: read_value = rx_head_data;
         ubrb_pkg::A_INTERRUPT_STATUS: read_value = interrupt_status;
         ubrb_pkg::A_LINE_STATUS:
            read_value = line_status & ubrb_pkg::MASK_LINE_STATUS;
         ubrb_pkg::A_SPECIAL_CHAR_STATUS: read_value = special_char_status;
         ubrb_pkg::A_MISC_STATUS: read_value = misc_view;
         ubrb_pkg::A_TX_FILL_COUNT: read_value = tx_count;
         ubrb_pkg::A_RX_FILL_COUNT: read_value = rx_count;
         ubrb_pkg::A_REVISION_CODE: read_value = REVISION_CODE;
         default: read_value = rw_q[host_req.addr];
      endcase
   end

   // the pre-clear value is captured on the same edge that clears
   always_ff @(posedge core_clk)
   begin
      if (rst)
         host_rdata <= 8'h00;
      else if (host_req.rd)
         host_rdata <= read_value;
   end

   // ----------------------------------------------------------------
   // fifo side effects
   // ----------------------------------------------------------------
   // a read of an empty receive fifo does not pop
   assign rx_pop = hit(host_req, 1'b1, ubrb_pkg::A_HOLDING) &&
                   (rx_count != 8'h00);

   always_ff @(posedge core_clk)
   begin
      if (rst)
         tx_push <= 1'b0;
      else
         tx_push <= wr_holding;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         tx_push_data <= 8'h00;
      else if (wr_holding)
         tx_push_data <= host_req.wdata;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         fifo_flush <= 1'b0;
      else
         fifo_flush <= hit(host_req, 1'b0, ubrb_pkg::A_MODE_CONTROL_2) &&
                       host_req.wdata[ubrb_pkg::FIFO_FLUSH_BIT];
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_reset_values;
      @(posedge core_clk)
      rst |=> interrupt_status == 8'h60 && cfg.line_control == 8'h05;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("wrong reset of status or line control");

   property p_reset_clock;
      @(posedge core_clk)
      rst |=> cfg.fifo_trigger_levels == 8'hFF &&
              cfg.multiplier_predivider_config == 8'h01 &&
              cfg.baud_divisor_low == 8'h01 &&
              cfg.clock_source_select == 8'h08 &&
              cfg.mode_control_1 == 8'h00;
   endproperty
   a_reset_clock: assert property (p_reset_clock)
      else $error("wrong reset of clock or trigger registers");

   property p_readback;
      @(posedge core_clk) disable iff (rst)
      (host_req.wr && host_req.addr == 5'h0C) ##1
      (host_req.rd && !host_req.wr && host_req.addr == 5'h0C)
      |=> host_rdata == $past(host_req.wdata, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("register did not read back last write");

   property p_pop;
      @(posedge core_clk) disable iff (rst)
      rx_pop |-> host_req.rd && host_req.addr == 5'h00 &&
                 rx_count != 8'h00;
   endproperty
   a_pop: assert property (p_pop)
      else $error("receive pop without holding read");

   property p_push;
      @(posedge core_clk) disable iff (rst)
      host_req.wr && host_req.addr == 5'h00
      |=> tx_push && tx_push_data == $past(host_req.wdata);
   endproperty
   a_push: assert property (p_push)
      else $error("transmit write did not push byte");

   property p_flush;
      @(posedge core_clk) disable iff (rst)
      $rose(fifo_flush) |-> $past(host_req.wr) &&
         $past(host_req.addr) == 5'h0A && $past(host_req.wdata[1]);
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush pulse without flush write");

   property p_revision;
      @(posedge core_clk) disable iff (rst)
      host_req.rd && host_req.addr == 5'h1F
      |=> host_rdata == REVISION_CODE && host_rdata != 8'h00;
   endproperty
   a_revision: assert property (p_revision)
      else $error("revision read wrong");

   property p_spare_bits;
      @(posedge core_clk) disable iff (rst)
      host_req.rd && (host_req.addr == 5'h03 || host_req.addr == 5'h04)
      |=> host_rdata[6] == 1'b0;
   endproperty
   a_spare_bits: assert property (p_spare_bits)
      else $error("spare bit read nonzero");

   property p_fill;
      @(posedge core_clk) disable iff (rst)
      host_req.rd && host_req.addr == 5'h12
      |=> host_rdata == $past(rx_count);
   endproperty
   a_fill: assert property (p_fill)
      else $error("fill count read wrong");

   property p_holding_read;
      @(posedge core_clk) disable iff (rst)
      host_req.rd && host_req.addr == ubrb_pkg::A_HOLDING
      |=> host_rdata == $past(rx_head_data);
   endproperty
   a_holding_read: assert property (p_holding_read)
      else $error("holding read did not return receive word");

   property p_cfg_write;
      @(posedge core_clk) disable iff (rst)
      host_req.wr && host_req.addr == ubrb_pkg::A_LINE_CONTROL
      |=> cfg.line_control == $past(host_req.wdata);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("line control write not applied");

   property p_flush_req;
      @(posedge core_clk) disable iff (rst)
      host_req.wr && host_req.addr == ubrb_pkg::A_MODE_CONTROL_2 &&
      host_req.wdata[ubrb_pkg::FIFO_FLUSH_BIT]
      |=> fifo_flush;
   endproperty
   a_flush_req: assert property (p_flush_req)
      else $error("flush write gave no flush pulse");

   property p_misc_ready;
      @(posedge core_clk) disable iff (rst)
      host_req.rd && host_req.addr == ubrb_pkg::A_MISC_STATUS
      |=> host_rdata[ubrb_pkg::CLOCK_READY_BIT] == $past(clock_ready);
   endproperty
   a_misc_ready: assert property (p_misc_ready)
      else $error("clock ready bit read wrong");

   property p_reset_outputs;
      @(posedge core_clk)
      rst |=> host_rdata == 8'h00 && !tx_push && !fifo_flush &&
              misc_status == 8'h00;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs)
      else $error("wrong reset of outputs or status");

endmodule

// *** verification/ubrb_fifo_model.sv ***
// both fifos behind the register bank, modelled as queues
module ubrb_fifo_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // words arriving from the serial line
   input wire logic rx_load,
   input wire logic [7:0] rx_load_data,
   // register bank side
   input wire logic rx_pop,
   input wire logic tx_push,
   input wire logic [7:0] tx_push_data,
   input wire logic fifo_flush,
   output logic [7:0] rx_head_data,
   output logic [7:0] rx_count,
   output logic [7:0] tx_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rxq[$];
   logic [7:0] txq[$];
   logic [7:0] last_head = 8'h00;

   // outputs move by non-blocking update so the bank samples old values
   always @(posedge core_clk)
   begin
      if (rst || fifo_flush)
      begin
         rxq.delete();
         txq.delete();
      end
      else
      begin
         if (rx_pop && rxq.size() > 0)
            last_head = rxq.pop_front();
         if (rx_load)
            rxq.push_back(rx_load_data);
         if (tx_push)
            txq.push_back(tx_push_data);
      end
      rx_count <= 8'(rxq.size());
      tx_count <= 8'(txq.size());
      // an empty fifo shows no stale word
      rx_head_data <= (rxq.size() > 0) ? rxq[0] : ~last_head;
   end
endmodule

// *** verification/tb_ubrb_regs.sv ***
module tb_ubrb_regs;
   timeunit 1ns;
   timeprecision 1ps;
   // arbitrary identification value for this run
   localparam logic [7:0] REV = 8'h3C;
   logic [7:0] line_stat = 8'hC3;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   ubrb_pkg::ubrb_host_req_t host_req = '0;
   logic [7:0] host_rdata, rx_head_data, rx_count, tx_count, tx_push_data;
   logic rx_pop, tx_push, fifo_flush;
   logic rx_load = 1'b0;
   logic [7:0] rx_load_data = 8'h00;
   logic [7:0] int_ev = 8'h00;
   logic [7:0] spc_ev = 8'h00;
   logic [7:0] misc_ev = 8'h00;
   logic clock_ready = 1'b0;
   ubrb_pkg::ubrb_cfg_t cfg;
   int n_fail = 0;
   int cmp_count = 0;
   logic [7:0] v;
   logic [7:0] e;

   ubrb_regs #(.REVISION_CODE(REV)) i_dut (
      .core_clk(core_clk), .rst(rst), .host_req(host_req),
      .host_rdata(host_rdata), .rx_head_data(rx_head_data),
      .rx_count(rx_count), .rx_pop(rx_pop), .tx_count(tx_count),
      .tx_push(tx_push), .tx_push_data(tx_push_data),
      .fifo_flush(fifo_flush), .interrupt_events(int_ev),
      .line_status(line_stat), .special_char_events(spc_ev),
      .misc_events(misc_ev), .clock_ready(clock_ready), .cfg(cfg));

   ubrb_fifo_model i_fifo (
      .core_clk(core_clk), .rst(rst), .rx_load(rx_load),
      .rx_load_data(rx_load_data), .rx_pop(rx_pop), .tx_push(tx_push),
      .tx_push_data(tx_push_data), .fifo_flush(fifo_flush),
      .rx_head_data(rx_head_data), .rx_count(rx_count),
      .tx_count(tx_count));

   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // expectations and host access
   // ----------------------------------------------------------------
   function automatic logic [7:0] msk(input logic [4:0] a);
      case (a)
         5'h03, 5'h05, 5'h0E, 5'h1B: return 8'h3F;
         5'h07: return 8'h6F;
         5'h1E: return 8'h9F;
         5'h02, 5'h04, 5'h06, 5'h08, 5'h11, 5'h12, 5'h1F: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction

   // live or fixed bits that no write reaches
   function automatic logic [7:0] fixed(input logic [4:0] a);
      case (a)
         5'h04: return line_stat & 8'hBF;
         5'h1F: return REV;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] rst_val(input logic [4:0] a);
      case (a)
         5'h02: return 8'h60;
         5'h0B: return 8'h05;
         5'h10: return 8'hFF;
         5'h1A, 5'h1C: return 8'h01;
         5'h1E: return 8'h08;
         default: return 8'h00;
      endcase
   endfunction

   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // strobes stay up until idle, so back-to-back access is possible
   task automatic acc(input logic r, input logic w, input logic [4:0] a,
                      input logic [7:0] d);
      host_req = '{rd: r, wr: w, addr: a, wdata: d};
      @(posedge core_clk);
      #1;
   endtask

   task automatic idle();
      host_req = '0;
      @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      acc(1'b0, 1'b1, a, d);
      idle();
   endtask

   task automatic rdc(input string nm, input logic [4:0] a,
                      input logic [7:0] exp);
      acc(1'b1, 1'b0, a, 8'h00);
      v = host_rdata;
      idle();
      chk(nm, v, exp);
   endtask

   task automatic load_rx2(input logic [7:0] d0, input logic [7:0] d1);
      rx_load = 1'b1;
      rx_load_data = d0;
      @(posedge core_clk);
      #1;
      rx_load_data = d1;
      @(posedge core_clk);
      #1;
      rx_load = 1'b0;
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #(25 * 5000);
      n_fail++;
      final_report();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge core_clk);
      #1;
      rst = 1'b0;
      for (int a = 1; a < 32; a++)
         rdc("reset value", 5'(a), rst_val(5'(a)) | fixed(5'(a)));
      for (int a = 1; a < 32; a++)
         wr(5'(a), 8'(a) ^ 8'hA5);
      for (int a = 1; a < 32; a++)
      begin
         e = ((8'(a) ^ 8'hA5) & msk(5'(a))) | fixed(5'(a));
         rdc("readback", 5'(a), e);
      end
      chk("line control out", cfg.line_control, 8'hAE);
      chk("mode two out", cfg.mode_control_2, 8'hAF);
      int_ev = 8'h81;
      spc_ev = 8'hFF;
      misc_ev = 8'hFF;
      @(posedge core_clk);
      #1;
      int_ev = 8'h00;
      spc_ev = 8'h00;
      misc_ev = 8'h00;
      clock_ready = 1'b1;
      rdc("int status", 5'h02, 8'h81);
      rdc("int cleared", 5'h02, 8'h00);
      rdc("special status", 5'h06, 8'h3F);
      rdc("special cleared", 5'h06, 8'h00);
      rdc("misc status", 5'h08, 8'h6F);
      rdc("misc cleared", 5'h08, 8'h20);
      rdc("line status kept", 5'h04, 8'h83);
      line_stat = 8'h7E;
      rdc("line status live", 5'h04, 8'h3E);
      int_ev = 8'h04;
      acc(1'b1, 1'b0, 5'h02, 8'h00);
      int_ev = 8'h00;
      chk("status at event", host_rdata, 8'h00);
      idle();
      rdc("event kept", 5'h02, 8'h04);
      for (int i = 0; i < 3; i++)
      begin
         acc(1'b0, 1'b1, 5'h00, 8'h30 + 8'(i));
         chk("push strobe", 8'(tx_push), 8'h01);
         chk("push byte", tx_push_data, 8'h30 + 8'(i));
      end
      idle();
      chk("push ends", 8'(tx_push), 8'h00);
      rdc("tx fill", 5'h11, 8'h03);
      load_rx2(8'h5A, 8'hC6);
      rdc("rx fill", 5'h12, 8'h02);
      acc(1'b1, 1'b0, 5'h00, 8'h00);
      chk("rx oldest", host_rdata, 8'h5A);
      acc(1'b1, 1'b0, 5'h00, 8'h00);
      chk("rx next", host_rdata, 8'hC6);
      idle();
      rdc("rx drained", 5'h12, 8'h00);
      rdc("rx empty read", 5'h00, 8'h39);
      rdc("rx still empty", 5'h12, 8'h00);
      load_rx2(8'h11, 8'h22);
      wr(5'h00, 8'h77);
      rdc("tx fill more", 5'h11, 8'h04);
      wr(5'h0A, 8'h02);
      rdc("tx flushed", 5'h11, 8'h00);
      rdc("rx flushed", 5'h12, 8'h00);
      rdc("flush bit stored", 5'h0A, 8'h02);
      acc(1'b0, 1'b1, 5'h0C, 8'h9D);
      acc(1'b1, 1'b0, 5'h0C, 8'h00);
      chk("read after write", host_rdata, 8'h9D);
      rst = 1'b1;
      idle();
      idle();
      rst = 1'b0;
      rdc("line control reset", 5'h0B, 8'h05);
      chk("clock source reset", cfg.clock_source_select, 8'h08);
      final_report();
   end
endmodule
